// >>> bench/light_screen_config_reset_status_bench.sv
// Self-checking bench for the config/reset/status block
`timescale 1ns/1ns
`default_nettype none
module light_screen_config_reset_status_bench;
  // ------------
  // Harness
  // ------------
  logic clk_sys_i = 1'h0;
  logic rst_i = 1'h1;
  lscrs_pkg::lscrs_bank_s bank_a_i, bank_b_i;
  logic channel_code_two_i, reset_switch_closed_i;
  logic emitter_test_open_i, internal_fault_i, emitter_fault_i;
  logic [7:0] zone_blocked_i;
  logic [23:0] display_o;
  logic [7:0] emitter_display_o;
  logic safety_switching_outputs_o, aux_output_o, aux_available_o;
  logic dual_channel_monitor_o, reduced_resolution_o, reset_led_o;
  logic [1:0] channel_code_o;
  lscrs_pkg::lscrs_led_s status_led_o, emitter_led_o;
  lscrs_pkg::lscrs_led_s [7:0] zone_led_o;
  int bad_count = 0;
  int checks = 0;
  localparam logic [23:0] SHOW_TRIP = {lscrs_pkg::DIG_BLANK,
    lscrs_pkg::DIG_DASH, lscrs_pkg::DIG_BLANK};
  localparam logic [23:0] SHOW_LATCH = {lscrs_pkg::DIG_BLANK,
    lscrs_pkg::DIG_LATCH, lscrs_pkg::DIG_BLANK};
  localparam logic [23:0] SHOW_CHANGE = {lscrs_pkg::DIG_ERR,
    lscrs_pkg::DIG_BLANK, lscrs_pkg::ERR_CHANGE};
  localparam logic [23:0] SHOW_TRIPSEL = {lscrs_pkg::DIG_ERR,
    lscrs_pkg::DIG_BLANK, lscrs_pkg::ERR_TRIPSEL};
  localparam logic [23:0] SHOW_EM_DASH = {16'h0000, lscrs_pkg::DIG_DASH};
  localparam logic [23:0] SHOW_EM_ERR = {16'h0000, lscrs_pkg::ERR_FAULT};
  // Short counts keep the run small; expectations use these values
  lscrs_top #(.RESET_MIN(20), .RESET_MAX(100), .DEBOUNCE(2), .BLINK(4)) dut (
    .clk_sys_i, .rst_i, .bank_a_i, .bank_b_i, .channel_code_two_i,
    .reset_switch_closed_i, .emitter_test_open_i, .zone_blocked_i,
    .internal_fault_i, .emitter_fault_i, .safety_switching_outputs_o,
    .aux_output_o, .aux_available_o, .dual_channel_monitor_o,
    .reduced_resolution_o, .channel_code_o, .status_led_o, .reset_led_o,
    .zone_led_o, .display_o, .emitter_led_o, .emitter_display_o
  );
  lscrs_operator op (.clk_sys_i, .bank_a_o(bank_a_i), .bank_b_o(bank_b_i),
    .code_two_o(channel_code_two_i), .closed_o(reset_switch_closed_i));
  initial begin
    forever #50 clk_sys_i = ~clk_sys_i;
  end
  function automatic lscrs_pkg::lscrs_bank_s mk(input logic l, d, r);
    return lscrs_pkg::lscrs_bank_s'({l, d, r});
  endfunction
  task automatic cmp1(input logic got, input logic exp, input string what);
    checks++;
    if (got !== exp) begin
      bad_count++;
      $display("mismatch at %0t: %s", $time, what);
    end
  endtask
  task automatic cmpw(input logic [23:0] got, input logic [23:0] exp,
                      input string what);
    checks++;
    if (got !== exp) begin
      bad_count++;
      $display("mismatch at %0t: %s", $time, what);
    end
  endtask
  task automatic wait_cyc(input int n);
    repeat (n) @(posedge clk_sys_i);
  endtask
  task automatic power_up(input lscrs_pkg::lscrs_bank_s a, b);
    op.set_cfg(a, b, 1'h0);
    rst_i <= 1'h1;
    wait_cyc(8);
    rst_i <= 1'h0;
    wait_cyc(60);
  endtask
  task automatic press_ok();
    op.press(50);
    wait_cyc(20);
  endtask
  // ------------
  // Scenarios
  // ------------
  task automatic sc_trip();
    power_up(mk(1'h0, 1'h0, 1'h0), mk(1'h0, 1'h0, 1'h0));
    cmp1(safety_switching_outputs_o, 1'h1, "trip start");
    cmp1(aux_available_o, 1'h1, "aux single");
    cmp1(channel_code_o == 2'h1, 1'h1, "code one");
    cmp1(reduced_resolution_o, 1'h0, "rr off");
    cmp1(status_led_o.green, 1'h1, "green on");
    zone_blocked_i <= 8'h08;
    wait_cyc(10);
    cmp1(zone_led_o[3].red, 1'h1, "zone four red");
    cmp1(zone_led_o[2].green, 1'h1, "zone three green");
    cmp1(safety_switching_outputs_o, 1'h0, "trip zone four");
    zone_blocked_i <= 8'h01;
    wait_cyc(10);
    cmp1(safety_switching_outputs_o, 1'h0, "trip block");
    cmp1(zone_led_o[1] == 2'h0, 1'h1, "upper zones off");
    cmp1(zone_led_o[0].red, 1'h1, "zone one red");
    zone_blocked_i <= 8'h00;
    wait_cyc(20);
    cmp1(safety_switching_outputs_o, 1'h1, "auto restore");
    cmpw(display_o, SHOW_TRIP, "trip shown");
  endtask
  task automatic sc_code();
    int code_n;
    code_n = 0;
    op.set_cfg(mk(1'h0, 1'h0, 1'h0), mk(1'h0, 1'h0, 1'h0), 1'h1);
    repeat (20) begin
      @(posedge clk_sys_i);
      code_n += (display_o[15:8] == lscrs_pkg::DIG_ZERO + 8'h02);
    end
    cmp1(code_n inside {[1:19]}, 1'h1, "code flash");
    wait_cyc(20);
    cmp1(channel_code_o == 2'h2, 1'h1, "code two");
    cmp1(safety_switching_outputs_o, 1'h1, "code no lock");
  endtask
  task automatic sc_change();
    int red_n;
    red_n = 0;
    op.set_cfg(mk(1'h0, 1'h0, 1'h1), mk(1'h0, 1'h0, 1'h1), 1'h1);
    wait_cyc(10);
    cmp1(safety_switching_outputs_o, 1'h0, "change lock");
    cmp1(reset_led_o, 1'h0, "wait led");
    repeat (20) begin
      @(posedge clk_sys_i);
      red_n += status_led_o.red;
    end
    cmp1(red_n inside {[1:19]}, 1'h1, "lock flash");
    cmpw(display_o, SHOW_CHANGE, "change code");
    op.set_cfg(mk(1'h0, 1'h0, 1'h0), mk(1'h0, 1'h0, 1'h0), 1'h1);
    op.press(8);
    wait_cyc(20);
    cmp1(safety_switching_outputs_o, 1'h0, "short press");
    op.press(150);
    wait_cyc(20);
    cmp1(safety_switching_outputs_o, 1'h0, "long press");
    press_ok();
    cmp1(safety_switching_outputs_o, 1'h1, "lock cleared");
  endtask
  task automatic sc_fault();
    internal_fault_i <= 1'h1;
    press_ok();
    cmp1(safety_switching_outputs_o, 1'h0, "fault held");
    internal_fault_i <= 1'h0;
    wait_cyc(10);
    cmp1(safety_switching_outputs_o, 1'h0, "needs reset");
    press_ok();
    cmp1(safety_switching_outputs_o, 1'h1, "fault cleared");
  endtask
  task automatic sc_latch();
    power_up(mk(1'h1, 1'h1, 1'h1), mk(1'h1, 1'h1, 1'h1));
    cmp1(safety_switching_outputs_o, 1'h0, "latch start");
    cmp1(reduced_resolution_o, 1'h1, "rr on");
    cmp1(dual_channel_monitor_o, 1'h1, "dual mon");
    cmp1(aux_available_o, 1'h0, "aux gone");
    press_ok();
    cmp1(safety_switching_outputs_o, 1'h1, "latch reset");
    cmpw(display_o, SHOW_LATCH, "latch shown");
    zone_blocked_i <= 8'h01;
    wait_cyc(10);
    zone_blocked_i <= 8'h00;
    wait_cyc(20);
    cmp1(safety_switching_outputs_o, 1'h0, "latched stop");
    press_ok();
    cmp1(safety_switching_outputs_o, 1'h1, "stop cleared");
  endtask
  task automatic sc_mismatch();
    power_up(mk(1'h1, 1'h0, 1'h0), mk(1'h0, 1'h0, 1'h0));
    press_ok();
    cmp1(safety_switching_outputs_o, 1'h0, "bank lock");
    cmp1(reset_led_o, 1'h0, "mode lock");
    cmpw(display_o, SHOW_TRIPSEL, "trip sel code");
  endtask
  task automatic sc_emitter();
    int green_n;
    green_n = 0;
    power_up(mk(1'h0, 1'h0, 1'h0), mk(1'h0, 1'h0, 1'h0));
    emitter_test_open_i <= 1'h1;
    repeat (20) begin
      @(posedge clk_sys_i);
      green_n += emitter_led_o.green;
    end
    cmp1(green_n inside {[1:19]}, 1'h1, "test flash");
    cmp1(emitter_led_o.red, 1'h0, "test not red");
    cmpw({16'h0000, emitter_display_o}, SHOW_EM_DASH, "test dash");
    emitter_test_open_i <= 1'h0;
    green_n = 0;
    emitter_fault_i <= 1'h1;
    wait_cyc(10);
    emitter_fault_i <= 1'h0;
    press_ok();
    repeat (20) begin
      @(posedge clk_sys_i);
      green_n += emitter_led_o.green;
    end
    cmp1(green_n == 0, 1'h1, "emitter stays locked");
    cmpw({16'h0000, emitter_display_o}, SHOW_EM_ERR, "emitter code");
  endtask
  task automatic tally_and_finish();
    $display("checks %0d mismatches %0d", checks, bad_count);
    if (bad_count == 0 && checks > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask
  initial begin
    emitter_test_open_i <= 1'h0;
    zone_blocked_i <= 8'h00;
    internal_fault_i <= 1'h0;
    emitter_fault_i <= 1'h0;
    sc_trip();
    sc_code();
    sc_change();
    sc_fault();
    sc_latch();
    sc_mismatch();
    sc_emitter();
    tally_and_finish();
  end
  // Whole sequence needs about 1200 cycles
  initial begin
    wait_cyc(20000);
    bad_count++;
    tally_and_finish();
  end
endmodule
`default_nettype wire

// >>> bench/lscrs_asserts.sv
// Port-level checks bound to the config/reset/status block
`timescale 1ns/1ns
`default_nettype none
module lscrs_asserts #(
  parameter int unsigned ZONES = 8
) (
  input wire logic clk_sys_i,
  input wire logic rst_i,
  input wire logic [ZONES-1:0] zone_blocked_i,
  input wire logic internal_fault_i,
  input wire logic safety_switching_outputs_o,
  input wire logic aux_output_o,
  input wire logic aux_available_o,
  input wire logic [1:0] channel_code_o,
  input wire lscrs_pkg::lscrs_led_s status_led_o,
  input wire logic reset_led_o,
  input wire lscrs_pkg::lscrs_led_s [ZONES-1:0] zone_led_o
);
  // ------------
  // Checks
  // ------------
  default clocking @(posedge clk_sys_i); endclocking
  default disable iff (rst_i);
  logic on;
  assign on = safety_switching_outputs_o;
  code_range_a: assert property (
    channel_code_o == 2'h1 || channel_code_o == 2'h2)
    else $error("channel code out of range");
  beam_trip_a: assert property (
    $rose(zone_blocked_i[0]) |-> ##[1:6] !on)
    else $error("outputs stayed on with beam blocked");
  fault_off_a: assert property (
    $rose(internal_fault_i) |-> ##[1:8] !on)
    else $error("outputs stayed on after fault");
  on_not_red_a: assert property (
    on && $past(on) |-> !status_led_o.red)
    else $error("status red while outputs on");
  run_led_a: assert property (
    on && $past(on) |-> reset_led_o)
    else $error("reset indicator off in run");
  aux_gate_a: assert property (
    aux_output_o |-> aux_available_o)
    else $error("aux output active while unavailable");
  aux_copy_a: assert property (
    (on && aux_available_o)[*3] |-> aux_output_o)
    else $error("aux output does not follow outputs");
  zone_sync_a: assert property (
    zone_blocked_i[0][*4] |-> zone_led_o[ZONES-1:1] == '0)
    else $error("upper zones lit with first beam blocked");
  cover property ($rose(on));
  cover property (internal_fault_i && !on);
  cover property (channel_code_o == 2'h2);
endmodule
bind lscrs_top lscrs_asserts #(.ZONES(ZONES)) u_chk (
  .clk_sys_i, .rst_i, .zone_blocked_i, .internal_fault_i,
  .safety_switching_outputs_o, .aux_output_o, .aux_available_o,
  .channel_code_o, .status_led_o, .reset_led_o, .zone_led_o
);
`default_nettype wire

// >>> bench/lscrs_operator.sv
// Operator model: configuration switches and the manual reset switch
`timescale 1ns/1ns
`default_nettype none
module lscrs_operator (
  input wire logic clk_sys_i,
  output lscrs_pkg::lscrs_bank_s bank_a_o,
  output lscrs_pkg::lscrs_bank_s bank_b_o,
  output logic code_two_o,
  output logic closed_o
);
  // ------------
  // Switches
  // ------------
  initial begin
    bank_a_o = '0;
    bank_b_o = '0;
    code_two_o = 1'h0;
    closed_o = 1'h0;
  end
  task automatic set_cfg(input lscrs_pkg::lscrs_bank_s a,
                         input lscrs_pkg::lscrs_bank_s b, input logic c);
    @(posedge clk_sys_i);
    bank_a_o <= a;
    bank_b_o <= b;
    code_two_o <= c;
  endtask
  // Closure of n cycles then release; length decides validity
  task automatic press(input int n);
    @(posedge clk_sys_i);
    closed_o <= 1'h1;
    repeat (n) @(posedge clk_sys_i);
    closed_o <= 1'h0;
  endtask
endmodule
`default_nettype wire

// >>> rtl/lscrs_pkg.sv
// Shared constants and carriers for the light screen config/reset/status block
package lscrs_pkg;

  // Timing at 10 MHz
  localparam int unsigned CLK_HZ = 10_000_000;
  localparam int unsigned RESET_MIN_MS = 250;
  localparam int unsigned RESET_MAX_MS = 2000;
  localparam int unsigned RESET_MIN_CYC = (CLK_HZ / 1000) * RESET_MIN_MS;
  localparam int unsigned RESET_MAX_CYC = (CLK_HZ / 1000) * RESET_MAX_MS;
  localparam int unsigned DEBOUNCE_MS = 10;
  localparam int unsigned DEBOUNCE_CYC = (CLK_HZ / 1000) * DEBOUNCE_MS;
  localparam int unsigned BLINK_MS = 250;
  localparam int unsigned BLINK_CYC = (CLK_HZ / 1000) * BLINK_MS;
  localparam int unsigned CODE_FLASHES = 3;

  // Three-digit display codes (one byte per digit)
  localparam logic [7:0] DIG_BLANK = 8'h20;
  localparam logic [7:0] DIG_DASH = 8'h2d;
  localparam logic [7:0] DIG_LATCH = 8'h4c;
  localparam logic [7:0] DIG_ERR = 8'h45;
  localparam logic [7:0] DIG_ZERO = 8'h30;

  // Lockout causes shown as the error digit
  localparam logic [7:0] ERR_BANK = 8'h01;
  localparam logic [7:0] ERR_CHANGE = 8'h02;
  localparam logic [7:0] ERR_TRIPSEL = 8'h03;
  localparam logic [7:0] ERR_FAULT = 8'h04;

  // One bank of configuration switches
  typedef struct packed {
    logic latch_sel;
    logic dual_channel_monitor_position;
    logic reduced_resolution_select;
  } lscrs_bank_s;

  // Bicolour indicator drive
  typedef struct packed {
    logic red;
    logic green;
  } lscrs_led_s;

  typedef enum logic [3:0] {
    ST_POWERUP = 4'b0001,
    ST_WAIT = 4'b0010,
    ST_RUN = 4'b0100,
    ST_LOCK = 4'b1000
  } lscrs_state_e;

endpackage

// >>> rtl/lscrs_top.sv
// Receiver and emitter configuration, manual reset and indicator logic
// ---------------------------------------------------------------------
// What this block does
// - At power-up, mismatched switch banks A and B force lockout.
// - Any non-channel-code switch change while powered forces lockout.
// - Channel code is one switch, value 1 or 2, shared with emitter.
// - Channel code change in run mode never causes lockout.
// - Disagreeing trip/latch switches show an error code.
// - Trip restores outputs when beams clear; latch waits for manual reset.
// - Monitor switch picks single-channel, or dual-channel (also no monitor).
// - Aux output mirrors safety outputs only in single-channel monitoring.
// - Reduced resolution only when both reduced-resolution switches enable it.
// - Valid reset is a closure of 1/4 to 2 s then release.
// - A closure longer than 2 s is ignored.
// - Valid reset clears latch; leaves lockout only once fault is gone.
// - Trip mode needs manual reset only to leave lockout.
// - Latch mode needs reset at power-up, after stop, after lockout.
// - Emitter leaves lockout only by power cycle.
// - Status LED green when outputs on, red off, flashing red lockout.
// - Yellow reset LED shows run mode versus waiting for reset.
// - Eight zone LEDs, each blocked/clear for one eighth of beams.
// - Display shows trip/latch normally and error code in lockout.
// - Displays flash channel code three times at power-up and on change.
// - Emitter LED shows power-up, run, test, lockout; error in lockout.
// - Beam 1 blocked turns zone LEDs two to eight off.
// ---------------------------------------------------------------------
`timescale 1ns/1ns
`default_nettype none
module lscrs_top #(
  parameter int unsigned RESET_MIN = lscrs_pkg::RESET_MIN_CYC,
  parameter int unsigned RESET_MAX = lscrs_pkg::RESET_MAX_CYC,
  parameter int unsigned DEBOUNCE = lscrs_pkg::DEBOUNCE_CYC,
  parameter int unsigned BLINK = lscrs_pkg::BLINK_CYC,
  parameter int unsigned ZONES = 8
) (
  input wire logic clk_sys_i,
  input wire logic rst_i,
  input wire lscrs_pkg::lscrs_bank_s bank_a_i,
  input wire lscrs_pkg::lscrs_bank_s bank_b_i,
  input wire logic channel_code_two_i,
  input wire logic reset_switch_closed_i,
  input wire logic emitter_test_open_i,
  input wire logic [ZONES-1:0] zone_blocked_i,
  input wire logic internal_fault_i,
  input wire logic emitter_fault_i,
  output logic safety_switching_outputs_o,
  output logic aux_output_o,
  output logic aux_available_o,
  output logic dual_channel_monitor_o,
  output logic reduced_resolution_o,
  output logic [1:0] channel_code_o,
  output lscrs_pkg::lscrs_led_s status_led_o,
  output logic reset_led_o,
  output lscrs_pkg::lscrs_led_s [ZONES-1:0] zone_led_o,
  output logic [23:0] display_o,
  output lscrs_pkg::lscrs_led_s emitter_led_o,
  output logic [7:0] emitter_display_o
);

  // ---------------------------------------------------------------
  // Input synchronisers
  // ---------------------------------------------------------------
  localparam int unsigned SW = 2 * $bits(lscrs_pkg::lscrs_bank_s) + 1;
  localparam int unsigned NIN = SW + 4 + ZONES;
  logic [NIN-1:0] sync1;
  logic [NIN-1:0] sync2;
  always_ff @(posedge clk_sys_i or posedge rst_i) begin
    if (rst_i) begin
      sync1 <= '0;
      sync2 <= '0;
    end else begin
      sync1 <= {bank_a_i, bank_b_i, channel_code_two_i,
                reset_switch_closed_i, emitter_test_open_i,
                internal_fault_i, emitter_fault_i, zone_blocked_i};
      sync2 <= sync1;
    end
  end

  lscrs_pkg::lscrs_bank_s sa;
  lscrs_pkg::lscrs_bank_s sb;
  logic s_code;
  logic s_rst_sw;
  logic s_test;
  logic s_fault;
  logic s_efault;
  logic [ZONES-1:0] s_zone;
  assign {sa, sb, s_code, s_rst_sw, s_test, s_fault, s_efault, s_zone} = sync2;

  // ---------------------------------------------------------------
  // Switch capture and checking
  // ---------------------------------------------------------------
  // Settings are captured once after synchronisers fill, then frozen
  logic [1:0] boot_cnt;
  logic captured;
  lscrs_pkg::lscrs_bank_s cfg;
  logic bank_err;
  logic change_err;
  logic trip_sel_err;
  always_ff @(posedge clk_sys_i or posedge rst_i) begin
    if (rst_i) begin
      boot_cnt <= '0;
      captured <= 1'b0;
      cfg <= '0;
      bank_err <= 1'b0;
      change_err <= 1'b0;
      trip_sel_err <= 1'b0;
    end else if (!captured) begin
      boot_cnt <= boot_cnt + 2'd1;
      if (boot_cnt == 2'd3) begin
        captured <= 1'b1;
        cfg <= sa;
        bank_err <= (sa != sb);
        trip_sel_err <= (sa.latch_sel != sb.latch_sel);
      end
    end else begin
      // Channel code sits outside the banks so it can never trip this
      // Level, so restoring the switches lets a reset leave lockout
      change_err <= (sa != cfg) || (sb != cfg);
    end
  end

  wire latch_mode = cfg.latch_sel;

  // ---------------------------------------------------------------
  // Reset input timing
  // ---------------------------------------------------------------
  logic [$clog2(DEBOUNCE+1)-1:0] db_cnt;
  logic rst_db;
  always_ff @(posedge clk_sys_i or posedge rst_i) begin
    if (rst_i) begin
      db_cnt <= '0;
      rst_db <= 1'b0;
    end else if (s_rst_sw == rst_db) begin
      db_cnt <= '0;
    end else if (db_cnt == DEBOUNCE[$clog2(DEBOUNCE+1)-1:0]) begin
      db_cnt <= '0;
      rst_db <= s_rst_sw;
    end else begin
      db_cnt <= db_cnt + 1'b1;
    end
  end

  // Counter saturates above the maximum so long closures stay invalid
  localparam int unsigned HW = $clog2(RESET_MAX + 2);
  logic [HW-1:0] hold_cnt;
  logic valid_reset;
  always_ff @(posedge clk_sys_i or posedge rst_i) begin
    if (rst_i) begin
      hold_cnt <= '0;
      valid_reset <= 1'b0;
    end else begin
      valid_reset <= 1'b0;
      if (rst_db) begin
        if (hold_cnt <= RESET_MAX[HW-1:0]) begin
          hold_cnt <= hold_cnt + 1'b1;
        end
      end else begin
        hold_cnt <= '0;
        // Release edge inside the window
        if (hold_cnt >= RESET_MIN[HW-1:0] &&
            hold_cnt <= RESET_MAX[HW-1:0]) begin
          valid_reset <= 1'b1;
        end
      end
    end
  end

  // ---------------------------------------------------------------
  // Operating state
  // ---------------------------------------------------------------
  lscrs_pkg::lscrs_state_e state;
  wire any_blocked = |s_zone;
  wire fault_now = s_fault | bank_err | change_err | trip_sel_err;
  always_ff @(posedge clk_sys_i or posedge rst_i) begin
    if (rst_i) begin
      state <= lscrs_pkg::ST_POWERUP;
    end else begin
      unique case (state)
        lscrs_pkg::ST_POWERUP: begin
          if (captured) begin
            if (fault_now) begin
              state <= lscrs_pkg::ST_LOCK;
            end else if (latch_mode) begin
              state <= lscrs_pkg::ST_WAIT;
            end else begin
              state <= lscrs_pkg::ST_RUN;
            end
          end
        end
        lscrs_pkg::ST_WAIT: begin
          if (fault_now) begin
            state <= lscrs_pkg::ST_LOCK;
          end else if (valid_reset && !any_blocked) begin
            state <= lscrs_pkg::ST_RUN;
          end
        end
        lscrs_pkg::ST_RUN: begin
          if (fault_now) begin
            state <= lscrs_pkg::ST_LOCK;
          end else if (latch_mode && any_blocked) begin
            state <= lscrs_pkg::ST_WAIT;
          end
        end
        lscrs_pkg::ST_LOCK: begin
          // Leave only once fault gone and reset correctly cycled
          if (!fault_now && valid_reset) begin
            state <= latch_mode ? lscrs_pkg::ST_WAIT : lscrs_pkg::ST_RUN;
          end
        end
      endcase
    end
  end

  // Emitter lockout is sticky until power cycle
  logic em_lock;
  always_ff @(posedge clk_sys_i or posedge rst_i) begin
    if (rst_i) begin
      em_lock <= 1'b0;
    end else if (s_efault) begin
      em_lock <= 1'b1;
    end
  end

  // ---------------------------------------------------------------
  // Blink timing and channel code flash
  // ---------------------------------------------------------------
  localparam int unsigned BW = $clog2(BLINK + 1);
  logic [BW-1:0] blink_cnt;
  logic blink;
  always_ff @(posedge clk_sys_i or posedge rst_i) begin
    if (rst_i) begin
      blink_cnt <= '0;
      blink <= 1'b0;
    end else if (blink_cnt == BLINK[BW-1:0]) begin
      blink_cnt <= '0;
      blink <= ~blink;
    end else begin
      blink_cnt <= blink_cnt + 1'b1;
    end
  end

  logic code_q;
  logic [2:0] flash_left;
  always_ff @(posedge clk_sys_i or posedge rst_i) begin
    if (rst_i) begin
      code_q <= 1'b0;
      flash_left <= 3'(2 * lscrs_pkg::CODE_FLASHES);
    end else begin
      code_q <= s_code;
      if (code_q != s_code) begin
        flash_left <= 3'(2 * lscrs_pkg::CODE_FLASHES);
      end else if (flash_left != 3'd0 &&
                   blink_cnt == BLINK[BW-1:0]) begin
        flash_left <= flash_left - 3'd1;
      end
    end
  end
  wire flashing = (flash_left != 3'd0);
  wire [7:0] code_digit = lscrs_pkg::DIG_ZERO + (s_code ? 8'h02 : 8'h01);

  // ---------------------------------------------------------------
  // Registered outputs
  // ---------------------------------------------------------------
  logic [7:0] err_code;
  always_comb begin
    err_code = lscrs_pkg::ERR_FAULT;
    // Trip/latch disagreement also trips the bank compare; name it first
    if (trip_sel_err) err_code = lscrs_pkg::ERR_TRIPSEL;
    else if (bank_err) err_code = lscrs_pkg::ERR_BANK;
    else if (change_err) err_code = lscrs_pkg::ERR_CHANGE;
  end

  wire run = (state == lscrs_pkg::ST_RUN);
  wire lock = (state == lscrs_pkg::ST_LOCK);
  wire outs_on = run && !any_blocked;

  always_ff @(posedge clk_sys_i or posedge rst_i) begin
    if (rst_i) begin
      safety_switching_outputs_o <= 1'b0;
      aux_output_o <= 1'b0;
      aux_available_o <= 1'b0;
      dual_channel_monitor_o <= 1'b0;
      reduced_resolution_o <= 1'b0;
      channel_code_o <= 2'h1;
      status_led_o <= '0;
      reset_led_o <= 1'b0;
    end else begin
      safety_switching_outputs_o <= outs_on;
      aux_available_o <= !cfg.dual_channel_monitor_position;
      aux_output_o <= outs_on && !cfg.dual_channel_monitor_position;
      dual_channel_monitor_o <= cfg.dual_channel_monitor_position;
      // Both banks must request it
      reduced_resolution_o <= captured &&
        cfg.reduced_resolution_select && !bank_err;
      channel_code_o <= s_code ? 2'h2 : 2'h1;
      if (lock) begin
        status_led_o <= '{red: blink, green: 1'b0};
      end else begin
        status_led_o <= '{red: !outs_on, green: outs_on};
      end
      reset_led_o <= run;
    end
  end

  // Zone indicators; beam 1 gives sync for all beams
  always_ff @(posedge clk_sys_i or posedge rst_i) begin
    if (rst_i) begin
      zone_led_o <= '0;
    end else begin
      for (int i = 0; i < ZONES; i++) begin
        if (lock) begin
          zone_led_o[i] <= '0;
        end else if (i != 0 && s_zone[0]) begin
          zone_led_o[i] <= '0;
        end else begin
          zone_led_o[i] <= '{red: s_zone[i], green: !s_zone[i]};
        end
      end
    end
  end

  always_ff @(posedge clk_sys_i or posedge rst_i) begin
    if (rst_i) begin
      display_o <= {3{lscrs_pkg::DIG_BLANK}};
      emitter_display_o <= lscrs_pkg::DIG_BLANK;
      emitter_led_o <= '0;
    end else begin
      if (lock) begin
        display_o <= {lscrs_pkg::DIG_ERR, lscrs_pkg::DIG_BLANK,
                      err_code};
      end else if (flashing) begin
        display_o <= {lscrs_pkg::DIG_BLANK,
          blink ? code_digit : lscrs_pkg::DIG_BLANK,
          lscrs_pkg::DIG_BLANK};
      end else begin
        display_o <= {lscrs_pkg::DIG_BLANK,
          latch_mode ? lscrs_pkg::DIG_LATCH : lscrs_pkg::DIG_DASH,
          lscrs_pkg::DIG_BLANK};
      end
      // Emitter indicator and display
      if (em_lock) begin
        emitter_led_o <= '{red: blink, green: 1'b0};
        emitter_display_o <= lscrs_pkg::ERR_FAULT;
      end else if (flashing) begin
        emitter_led_o <= '{red: blink, green: 1'b0};
        emitter_display_o <= blink ? code_digit : lscrs_pkg::DIG_BLANK;
      end else if (s_test) begin
        emitter_led_o <= '{red: 1'b0, green: blink};
        emitter_display_o <= lscrs_pkg::DIG_DASH;
      end else begin
        emitter_led_o <= '{red: 1'b0, green: 1'b1};
        emitter_display_o <= lscrs_pkg::DIG_DASH;
      end
    end
  end

endmodule
`default_nettype wire
